// file: hw/spi_status_tx_buffer_and_rate.v
// serial port with transmit buffer, mode-fault logic and rate select
//
// Overview of operation
// - idle port with empty shifter loads a written byte, sets empty within two cycles
// - a second byte may wait in the buffer behind the shifting one
// - busy slave loads the shifter only after its current transfer ends
// - reset sets the transmit-empty flag
// - mode fault sets only with detection enabled; disabling keeps a set fault
// - master without fault detection ignores slave select; pin stays general I/O
// - master with fault detection takes the slave-select pin from general I/O
// - enabled slave always owns the slave-select pin
// - slave with detection off only stops mode-fault setting
// - rate select 00,01,10,11 gives divisor 2,8,32,128
// - master serial clock is base clock over twice the divisor
// - rate select ignored as slave; reset clears it
// - data write loads transmit buffer; data read returns separate receive buffer
// - each buffer-to-shifter move sets the transmit-empty flag unless a data write lands in the same cycle
// - a data register read clears receive-full unless a transfer completes in the same cycle
// - mode fault clears by status read while set, then data write
// - master faults on select low; slave faults on select rising mid-transfer
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`include "spi_defines.vh"
module spi_status_tx_buffer_and_rate
(
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        sclkIn,
  output reg         sclkOut,
  output wire        sclkOe,
  input  wire        mosiIn,
  output wire        mosiOut,
  output wire        mosiOe,
  input  wire        misoIn,
  output wire        misoOut,
  output wire        misoOe,
  input  wire        ssInN,
  output wire        ssPinOwned
);
  reg  [1:0] ctl_reg;
  reg  [1:0] rate_reg;
  reg        faultEn_reg;
  reg        modeFault_reg;
  reg        faultArmed_reg;
  reg        rxFull_reg;
  reg        txFull_reg;
  reg  [7:0] txBuf_reg;
  reg  [7:0] rxBuf_reg;
  reg  [7:0] shift_reg;
  reg        sampleBit_reg;
  reg  [3:0] bitCnt_reg;
  reg        busy_reg;
  reg        sclkPrev_reg;
  reg        ssPrev_reg;
  reg        awHave_reg;
  reg        wHave_reg;
  reg  [3:0] awAddr_reg;
  reg  [7:0] wData_reg;
  reg        wLane0_reg;
  wire       enabled;
  wire       isMaster;
  wire       tick;
  wire       doWrite;
  wire       doRead;
  wire       wrData;
  wire       rdData;
  wire       rdStatus;
  wire       loadShift;
  wire       sampleEdge;
  wire       shiftEdge;
  wire       lastBit;
  wire       masterFault;
  wire       slaveFault;
  wire       faultSet;
  wire       writeMapped;
  wire       readMapped;

  assign enabled  = ctl_reg[`CTL_ENABLE];
  assign isMaster = ctl_reg[`CTL_MASTER];

  // write channel: address and data latched independently, in either order
  assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_reg && !s_axi_bvalid;
  assign doWrite       = awHave_reg && wHave_reg;
  assign writeMapped   = (awAddr_reg == `OFS_CONTROL) || (awAddr_reg == `OFS_STATUS_CTRL)
                         || (awAddr_reg == `OFS_DATA);
  assign wrData        = doWrite && wLane0_reg && (awAddr_reg == `OFS_DATA);
  assign s_axi_arready = !s_axi_rvalid;
  assign doRead        = s_axi_arvalid && s_axi_arready;
  assign readMapped    = (s_axi_araddr == `OFS_CONTROL) || (s_axi_araddr == `OFS_STATUS_CTRL)
                         || (s_axi_araddr == `OFS_DATA);
  assign rdData        = doRead && (s_axi_araddr == `OFS_DATA);
  assign rdStatus      = doRead && (s_axi_araddr == `OFS_STATUS_CTRL);

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      awHave_reg   <= 1'b0;
      wHave_reg    <= 1'b0;
      awAddr_reg   <= 4'h0;
      wData_reg    <= 8'h00;
      wLane0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_reg  <= 1'b1;
        wData_reg  <= s_axi_wdata[7:0];
        wLane0_reg <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (doRead)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= readMapped ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `OFS_CONTROL:
            s_axi_rdata <= {30'h0000_0000, ctl_reg};
          `OFS_STATUS_CTRL:
            s_axi_rdata <= {24'h00_0000, rxFull_reg, 2'b00, modeFault_reg, !txFull_reg,
                            faultEn_reg, rate_reg};
          `OFS_DATA:
            s_axi_rdata <= {24'h00_0000, rxBuf_reg};
          default:
            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // control and rate fields
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctl_reg     <= `CTL_RESET;
      rate_reg    <= `RATE_RESET;
      faultEn_reg <= 1'b0;
    end
    else if (doWrite && wLane0_reg)
    begin
      if (awAddr_reg == `OFS_CONTROL)
        ctl_reg <= wData_reg[`CTL_MASTER:`CTL_ENABLE];
      if (awAddr_reg == `OFS_STATUS_CTRL)
      begin
        rate_reg    <= wData_reg[`ST_RATE_HI:`ST_RATE_LO];
        faultEn_reg <= wData_reg[`ST_FAULT_EN];
      end
    end
  end

  // pin ownership: slave always, master only with fault detection
  assign ssPinOwned = enabled && (!isMaster || faultEn_reg);

  // idle master, or slave with select high and no transfer, may load
  assign loadShift = enabled && txFull_reg && !busy_reg
                     && (isMaster || ssInN);

  spi_rate_divider u_rate
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (busy_reg && isMaster && enabled),
    .rateSel (rate_reg),
    .tick    (tick)
  );

  // master edges from divider ticks; slave edges from incoming clock
  assign sampleEdge = isMaster ? (busy_reg && tick && !sclkOut)
                               : (!ssInN && sclkIn && !sclkPrev_reg);
  assign shiftEdge  = isMaster ? (busy_reg && tick && sclkOut)
                               : (!ssInN && busy_reg && !sclkIn && sclkPrev_reg);
  assign lastBit    = shiftEdge && (bitCnt_reg == `BITS_PER_BYTE - 4'h1);

  // select level ignored by a master without detection
  assign masterFault = isMaster && !ssInN;
  assign slaveFault  = !isMaster && busy_reg && ssInN && !ssPrev_reg;
  assign faultSet    = enabled && faultEn_reg
                       && (masterFault || slaveFault);

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      txFull_reg    <= 1'b0;
      txBuf_reg     <= 8'h00;
      shift_reg     <= 8'h00;
      sampleBit_reg <= 1'b0;
      bitCnt_reg    <= 4'h0;
      busy_reg      <= 1'b0;
      sclkOut       <= 1'b0;
      sclkPrev_reg  <= 1'b0;
      ssPrev_reg    <= 1'b1;
      rxBuf_reg     <= 8'h00;
      rxFull_reg    <= 1'b0;
    end
    else
    begin
      sclkPrev_reg <= sclkIn;
      ssPrev_reg   <= ssInN;
      // buffer may hold a second byte while the shifter is busy
      if (wrData)
      begin
        txBuf_reg  <= wData_reg;
        txFull_reg <= 1'b1;
      end
      else if (loadShift)
        txFull_reg <= 1'b0;
      if (loadShift)
      begin
        shift_reg  <= txBuf_reg;
        bitCnt_reg <= 4'h0;
        busy_reg   <= isMaster;
      end
      else if (!enabled || slaveFault || (isMaster && faultSet))
      begin
        busy_reg   <= 1'b0;
        bitCnt_reg <= 4'h0;
        sclkOut    <= 1'b0;
      end
      else
      begin
        if (sampleEdge)
        begin
          sampleBit_reg <= isMaster ? misoIn : mosiIn;
          busy_reg      <= 1'b1;
          if (isMaster)
            sclkOut <= 1'b1;
        end
        if (shiftEdge)
        begin
          shift_reg  <= {shift_reg[6:0], sampleBit_reg};
          bitCnt_reg <= bitCnt_reg + 4'h1;
          if (isMaster)
            sclkOut <= 1'b0;
        end
        if (lastBit)
        begin
          busy_reg   <= 1'b0;
          bitCnt_reg <= 4'h0;
          if (!rxFull_reg)
            rxBuf_reg <= {shift_reg[6:0], sampleBit_reg};
        end
      end
      // completion wins over a same-cycle read
      if (lastBit && !loadShift)
        rxFull_reg <= 1'b1;
      else if (rdData)
        rxFull_reg <= 1'b0;
    end
  end

  // fault flag: status read with flag set arms, data write then clears
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      modeFault_reg  <= 1'b0;
      faultArmed_reg <= 1'b0;
    end
    else
    begin
      if (rdStatus && modeFault_reg)
        faultArmed_reg <= 1'b1;
      else if (wrData)
        faultArmed_reg <= 1'b0;
      if (faultSet)
        modeFault_reg <= 1'b1;
      else if (wrData && faultArmed_reg)
        modeFault_reg <= 1'b0;
    end
  end

  // pin drive
  assign sclkOe  = enabled && isMaster;
  assign mosiOe  = enabled && isMaster;
  assign mosiOut = shift_reg[7];
  assign misoOe  = enabled && !isMaster && !ssInN;
  assign misoOut = shift_reg[7];
endmodule // spi_status_tx_buffer_and_rate

// file: hw/spi_defines.vh
// register map, field positions, reset values and codes of the serial port
`ifndef SPI_DEFINES_VH
`define SPI_DEFINES_VH
`define OFS_CONTROL     4'h0
`define OFS_STATUS_CTRL 4'h4
`define OFS_DATA        4'h8
`define CTL_ENABLE      0
`define CTL_MASTER      1
`define CTL_RESET       2'h2
`define ST_RATE_LO      0
`define ST_RATE_HI      1
`define ST_FAULT_EN     2
`define ST_TX_EMPTY     3
`define ST_MODE_FAULT   4
`define ST_RX_FULL      7
`define RATE_RESET      2'h0
`define DIV_SEL_2       2'h0
`define DIV_SEL_8       2'h1
`define DIV_SEL_32      2'h2
`define DIV_SEL_128     2'h3
`define DIV_2           8'h02
`define DIV_8           8'h08
`define DIV_32          8'h20
`define DIV_128         8'h80
`define BITS_PER_BYTE   4'h8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// file: hw/spi_rate_divider.v
// serial clock half-period tick generator
`include "spi_defines.vh"
module spi_rate_divider
(
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       run,
  input  wire [1:0] rateSel,
  output reg        tick
);
  reg  [7:0] cnt_reg;
  reg  [7:0] divisor;

  // divisor codes: 2, 8, 32, 128
  always @*
  begin
    case (rateSel)
      `DIV_SEL_2:  divisor = `DIV_2;
      `DIV_SEL_8:  divisor = `DIV_8;
      `DIV_SEL_32: divisor = `DIV_32;
      default:     divisor = `DIV_128;
    endcase
  end

  // one tick every divisor cycles, so serial clock = base / (2 * divisor)
  always @(posedge ref_clk)
  begin
    if (srst || !run)
    begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end
    else if (cnt_reg == divisor - 8'h01)
    begin
      cnt_reg <= 8'h00;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule // spi_rate_divider

// file: bench/spi_port_checker.sv
// port-level assertions for the serial port block
module spi_port_checker
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclkOut,
  input wire logic sclkOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic ssPinOwned
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  b_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_drop_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response stuck");
  ar_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  r_drop_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data stuck");
  sclk_pace_a: assert property (
    $changed(sclkOut) |=> $stable(sclkOut)) else $error("serial clock too fast");
  slave_drive_a: assert property (
    misoOe |-> !sclkOe && !mosiOe) else $error("slave drives master pins");
  select_own_a: assert property (
    misoOe |-> ssPinOwned) else $error("slave lost select pin");
  master_pins_a: assert property (
    mosiOe == sclkOe) else $error("master pin enables differ");
endmodule // spi_port_checker

bind spi_status_tx_buffer_and_rate spi_port_checker chk_u
(
  .ref_clk(ref_clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiOe(mosiOe), .misoOe(misoOe),
  .ssPinOwned(ssPinOwned)
);

// file: bench/spi_peer_model.sv
// serial peer answering the master with a preloaded byte
module spi_peer_model
(
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shiftReg = 8'h00;
  assign miso = shiftReg[7];
  // capture on rising, shift on falling, msb first
  always @(posedge sclk)
    rxByte <= {rxByte[6:0], mosi};
  // stale bits shift in inverted so the line never rests
  always @(posedge load or negedge sclk)
    if (load)
      shiftReg <= txByte;
    else
      shiftReg <= {shiftReg[6:0], ~shiftReg[0]};
endmodule // spi_peer_model

// file: bench/spi_status_tx_buffer_and_rate_test.sv
// self-checking bench for the serial port block
`include "spi_defines.vh"
module spi_status_tx_buffer_and_rate_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, srst = 1, ssInN = 1, peerLoad = 0;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic        sclkOut, sclkOe, mosiOut, mosiOe, misoIn, misoOe, ssPinOwned;
  logic        sclkIn = 0, mosiIn = 0, misoOut;
  logic [7:0]  peerTx = 0, peerRx;
  int          err_count = 0, n_checks = 0;

  spi_status_tx_buffer_and_rate dut_u
  (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe), .mosiIn(mosiIn), .mosiOut(mosiOut),
    .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(misoOut), .misoOe(misoOe), .ssInN(ssInN),
    .ssPinOwned(ssPinOwned)
  );
  spi_peer_model peer_u
  (
    .sclk(sclkOut), .mosi(mosiOut), .load(peerLoad), .txByte(peerTx), .miso(misoIn),
    .rxByte(peerRx)
  );

  initial forever #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic axiWr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic waitRx;
    do axiRd(`OFS_STATUS_CTRL, rd, rs);
    while (rd[`ST_RX_FULL] !== 1'b1);
  endtask

  task automatic testReset;
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd, 32'h0000_0008);
    axiWr(4'hC, 8'h55, rs);
    chk(rs, `RESP_SLVERR);
    axiRd(4'hC, rd, rs);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic testRates;
    int half;
    int bdv[4] = '{2, 8, 32, 128};
    axiWr(`OFS_CONTROL, 8'h03, rs);
    for (int i = 0; i < 4; i++)
    begin
      peerTx   <= 8'hC3 - i[7:0];
      peerLoad <= 1'b1;
      axiWr(`OFS_STATUS_CTRL, i[7:0], rs);
      peerLoad <= 1'b0;
      axiWr(`OFS_DATA, 8'h5A + i[7:0], rs);
      do @(posedge ref_clk);
      while (sclkOut !== 1'b1);
      half = 0;
      do
      begin
        @(posedge ref_clk);
        half++;
      end
      while (sclkOut !== 1'b0);
      chk(half, bdv[i]);
      axiRd(`OFS_STATUS_CTRL, rd, rs);
      chk(rd[`ST_TX_EMPTY], 1'b1);
      waitRx;
      axiRd(`OFS_DATA, rd, rs);
      chk(rd, peerTx);
      chk(peerRx, 8'h5A + i[7:0]);
      axiRd(`OFS_STATUS_CTRL, rd, rs);
      chk(rd[`ST_RX_FULL], 1'b0);
    end
  endtask

  task automatic testQueue;
    axiWr(`OFS_STATUS_CTRL, 8'h00, rs);
    axiWr(`OFS_DATA, 8'h11, rs);
    axiWr(`OFS_DATA, 8'h22, rs);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_TX_EMPTY], 1'b0);
    waitRx;
    axiRd(`OFS_DATA, rd, rs);
    waitRx;
    chk(peerRx, 8'h22);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_TX_EMPTY], 1'b1);
    axiRd(`OFS_DATA, rd, rs);
  endtask

  task automatic testFault;
    @(posedge ref_clk);
    ssInN <= 1'b0;
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_MODE_FAULT], 1'b0);
    chk(ssPinOwned, 1'b0);
    axiWr(`OFS_STATUS_CTRL, 8'h04, rs);
    chk(ssPinOwned, 1'b1);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_MODE_FAULT], 1'b1);
    ssInN <= 1'b1;
    axiWr(`OFS_STATUS_CTRL, 8'h00, rs);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_MODE_FAULT], 1'b1);
    axiWr(`OFS_DATA, 8'h99, rs);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_MODE_FAULT], 1'b0);
    waitRx;
    axiRd(`OFS_DATA, rd, rs);
  endtask

  // slave side: n bits msb first, 2-cycle phases, miso taken before each rise
  task automatic slaveByte(input logic [7:0] m, input int n, output logic [7:0] s);
    s = 8'h00;
    for (int b = 7; b > 7 - n; b--)
    begin
      @(posedge ref_clk);
      mosiIn <= m[b];
      @(posedge ref_clk);
      s[b] = misoOut;
      sclkIn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sclkIn <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic testSlave;
    logic [7:0] got;
    axiWr(`OFS_CONTROL, 8'h01, rs);
    chk(ssPinOwned, 1'b1);
    axiWr(`OFS_STATUS_CTRL, 8'h03, rs);
    axiWr(`OFS_DATA, 8'hA5, rs);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_TX_EMPTY], 1'b1);
    ssInN <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(misoOe, 1'b1);
    chk(sclkOe, 1'b0);
    slaveByte(8'h3C, 8, got);
    chk(got, 8'hA5);
    axiRd(`OFS_DATA, rd, rs);
    chk(rd, 32'h0000_003C);
    axiWr(`OFS_DATA, 8'h66, rs);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_TX_EMPTY], 1'b0);
    slaveByte(8'hFF, 3, got);
    @(posedge ref_clk);
    ssInN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_MODE_FAULT], 1'b0);
    chk(rd[`ST_TX_EMPTY], 1'b1);
    axiWr(`OFS_STATUS_CTRL, 8'h07, rs);
    ssInN <= 1'b0;
    slaveByte(8'h00, 3, got);
    chk(got, 8'h60);
    @(posedge ref_clk);
    ssInN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axiRd(`OFS_STATUS_CTRL, rd, rs);
    chk(rd[`ST_MODE_FAULT], 1'b1);
  endtask

  task final_report;
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    testReset;
    testRates;
    testQueue;
    testFault;
    testSlave;
    final_report;
  end

  initial
  begin
    #(20000 * 40);
    err_count++;
    final_report;
  end
endmodule // spi_status_tx_buffer_and_rate_test
